// ===== rtl/irmt_pkg.sv
package irmt_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------------
    localparam logic [12:0] IDX_CONFIG = 13'h184a;
    localparam logic [12:0] IDX_COMMAND = 13'h184b;
    localparam logic [12:0] IDX_STATUS = 13'h184c;
    localparam logic [12:0] IDX_WRITE_WORD = 13'h184d;
    localparam logic [12:0] IDX_READ_WORD = 13'h184e;
    localparam int ADDR_W = 15;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_MODE_LO = 1;
    localparam int CMD_DIR_BIT = 7;
    localparam int CMD_TYPE_LO = 5;
    localparam int CMD_IDX_LO = 0;
    localparam int STS_PEND_BIT = 0;

    // ------------------------------------------------------------------
    // table geometry, reset values and timing
    // ------------------------------------------------------------------
    localparam int NUM_RATE = 24;
    localparam int ENTRY_W = 16;
    localparam int PORT_GROUP = 8;
    localparam logic [15:0] RATE_RESET = 16'h0014;
    localparam logic [15:0] BURST_RESET = 16'h0600;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam int BYTE_TIME_NS = 20;
    localparam int CLK_PERIOD_NS = 50;
    // table access stays busy this many cycles; pending is shown one cycle longer, through done
    localparam logic [1:0] ACCESS_CYCLES = 2'h2;

    typedef enum logic [1:0] {
        IRMT_MODE_PORT_PRI = 2'h0,
        IRMT_MODE_PORT = 2'h1,
        IRMT_MODE_PRI = 2'h2,
        IRMT_MODE_RSVD = 2'h3
    } irmt_mode_e;

    typedef enum logic [1:0] {
        IRMT_TBL_RSVD = 2'h0,
        IRMT_TBL_RATE = 2'h1,
        IRMT_TBL_CBS = 2'h2,
        IRMT_TBL_EBS = 2'h3
    } irmt_tbl_e;

    typedef struct packed {
        logic dir_read;
        irmt_tbl_e tbl;
        logic [4:0] idx;
    } irmt_cmd_s;

    typedef struct packed {
        logic enable;
        irmt_mode_e mode;
    } irmt_cfg_s;

    // packet key presented to the meter selector
    typedef struct packed {
        logic valid;
        logic [1:0] port;
        logic [4:0] pri;
    } irmt_key_s;

endpackage

// ===== rtl/irmt_table.sv
`timescale 1ns/1ps
// 16-bit metering table: 24 rate entries plus two burst sizes
module irmt_table (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire irmt_pkg::irmt_tbl_e wr_tbl,
    input wire logic [4:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire irmt_pkg::irmt_tbl_e rd_tbl,
    input wire logic [4:0] rd_idx,
    output logic [15:0] rd_data,
    input wire logic [4:0] mtr_idx,
    output logic [15:0] mtr_rate,
    output logic [15:0] cbs,
    output logic [15:0] ebs
);
    logic [15:0] rate_r [irmt_pkg::NUM_RATE];
    logic [15:0] cbs_r;
    logic [15:0] ebs_r;

    // ------------------------------------------------------------------
    // rate entries, one flop word per entry
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < irmt_pkg::NUM_RATE; gi++) begin : g_rate
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    rate_r[gi] <= irmt_pkg::RATE_RESET;
                end else if (wr_en && wr_tbl == irmt_pkg::IRMT_TBL_RATE
                             && wr_idx == 5'(gi)) begin
                    rate_r[gi] <= wr_data;
                end
            end
        end
    endgenerate

    // burst sizes; buckets elsewhere start from these defaults
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cbs_r <= irmt_pkg::BURST_RESET;
            ebs_r <= irmt_pkg::BURST_RESET;
        end else if (wr_en && wr_tbl == irmt_pkg::IRMT_TBL_CBS) begin
            cbs_r <= wr_data;
        end else if (wr_en && wr_tbl == irmt_pkg::IRMT_TBL_EBS) begin
            ebs_r <= wr_data;
        end
    end

    // read mux; out-of-range index gives zero rather than x
    always_comb begin
        rd_data = '0;
        unique case (rd_tbl)
            irmt_pkg::IRMT_TBL_RATE: begin
                if (rd_idx < 5'(irmt_pkg::NUM_RATE)) begin
                    rd_data = rate_r[rd_idx];
                end
            end
            irmt_pkg::IRMT_TBL_CBS: rd_data = cbs_r;
            irmt_pkg::IRMT_TBL_EBS: rd_data = ebs_r;
            irmt_pkg::IRMT_TBL_RSVD: rd_data = '0;
        endcase
    end

    assign mtr_rate = (mtr_idx < 5'(irmt_pkg::NUM_RATE)) ? rate_r[mtr_idx] : '0;
    assign cbs = cbs_r;
    assign ebs = ebs_r;
endmodule // irmt_table

// ===== rtl/irmt_select.sv
`timescale 1ns/1ps
// maps a packet's port and priority to a rate entry index
module irmt_select (
    input wire irmt_pkg::irmt_mode_e mode,
    input wire irmt_pkg::irmt_key_s key,
    output logic [4:0] idx,
    output logic idx_ok
);
    // ------------------------------------------------------------------
    // index per mode
    // ------------------------------------------------------------------
    always_comb begin
        idx = '0;
        idx_ok = 1'b0;
        unique case (mode)
            irmt_pkg::IRMT_MODE_PORT_PRI: begin
                // port group of eight, priority ascends from group base
                idx = 5'(key.port * irmt_pkg::PORT_GROUP) + 5'(key.pri[2:0]);
                idx_ok = key.port < 2'h3 && key.pri < 5'h08;
            end
            irmt_pkg::IRMT_MODE_PORT: begin
                idx = 5'(key.port);
                idx_ok = key.port < 2'h3;
            end
            irmt_pkg::IRMT_MODE_PRI: begin
                idx = key.pri;
                idx_ok = key.pri < 5'(irmt_pkg::NUM_RATE);
            end
            irmt_pkg::IRMT_MODE_RSVD: begin
                idx = '0; // reserved mode never meters
                idx_ok = 1'b0;
            end
        endcase
    end
endmodule // irmt_select

// ===== rtl/irmt_top.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module irmt_top (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [14:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic pkt_valid,
    input wire logic [1:0] pkt_port,
    input wire logic [4:0] pkt_pri,
    output logic meter_active,
    output logic [4:0] meter_idx,
    output logic [15:0] meter_rate,
    output logic [15:0] meter_cbs,
    output logic [15:0] meter_ebs
);
    // ------------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_DONE = 3'b100
    } irmt_st_e;

    irmt_st_e state_r;
    irmt_st_e state_nxt;
    irmt_pkg::irmt_cfg_s cfg_r;
    irmt_pkg::irmt_cmd_s cmd_r;
    logic [15:0] wword_r;
    logic [15:0] rword_r;
    logic pend_r;
    logic [1:0] cnt_r;
    logic [31:0] reg_rdata_r;
    logic meter_active_r;
    logic [4:0] meter_idx_r;
    logic [15:0] meter_rate_r;
    logic [15:0] meter_cbs_r;
    logic [15:0] meter_ebs_r;
    logic [12:0] idx_w;
    logic word_ok;
    logic cmd_wr;
    logic tbl_wr;
    logic [15:0] tbl_rd;
    logic [4:0] sel_idx;
    logic sel_ok;
    logic [15:0] sel_rate;
    logic [15:0] cbs_w;
    logic [15:0] ebs_w;
    irmt_pkg::irmt_key_s key_w;
    irmt_pkg::irmt_cmd_s wcmd_w;

    // byte addressing: word index sits above the two low bits
    assign idx_w = reg_addr[14:2];
    assign word_ok = reg_addr[1:0] == 2'h0;
    assign cmd_wr = reg_wr && word_ok && idx_w == irmt_pkg::IDX_COMMAND;
    assign wcmd_w = irmt_pkg::irmt_cmd_s'(reg_wdata[irmt_pkg::CMD_DIR_BIT:0]);
    assign key_w = '{valid: pkt_valid, port: pkt_port, pri: pkt_pri};

    // ------------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= '0;
        end else if (reg_wr && word_ok && idx_w == irmt_pkg::IDX_CONFIG) begin
            cfg_r.enable <= reg_wdata[irmt_pkg::CFG_EN_BIT];
            cfg_r.mode <= irmt_pkg::irmt_mode_e'(
                reg_wdata[irmt_pkg::CFG_MODE_LO +: 2]);
        end
    end

    // write word; low 16 bits only
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wword_r <= irmt_pkg::WORD_RESET;
        end else if (reg_wr && word_ok && idx_w == irmt_pkg::IDX_WRITE_WORD) begin
            wword_r <= reg_wdata[irmt_pkg::ENTRY_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // command register and access sequencer
    // ------------------------------------------------------------------
    // a command written while busy is ignored: the latched fields must stay
    // steady until the running access ends
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_r <= '0;
        end else if (cmd_wr && state_r == ST_IDLE) begin
            cmd_r <= wcmd_w;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: if (cmd_wr) state_nxt = ST_BUSY;
            ST_BUSY: if (cnt_r == irmt_pkg::ACCESS_CYCLES - 2'h1) state_nxt = ST_DONE;
            ST_DONE: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // cycle count inside the busy phase
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
        end else if (state_r == ST_BUSY) begin
            cnt_r <= cnt_r + 2'h1;
        end else begin
            cnt_r <= '0;
        end
    end

    // pending: set by command, cleared by hardware at completion
    // software has no way to abort an access, it can only wait for the clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_r <= 1'b0;
        end else if (state_r == ST_IDLE && cmd_wr) begin
            pend_r <= 1'b1;
        end else if (state_r == ST_DONE) begin
            pend_r <= 1'b0;
        end
    end

    // table commit happens in the done cycle
    assign tbl_wr = state_r == ST_DONE && !cmd_r.dir_read;

    // read result lands one edge before pending drops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rword_r <= irmt_pkg::WORD_RESET;
        end else if (state_r == ST_BUSY && state_nxt == ST_DONE && cmd_r.dir_read) begin
            rword_r <= tbl_rd;
        end
    end

    // ------------------------------------------------------------------
    // storage and meter selection
    // ------------------------------------------------------------------
    irmt_table u_table (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wr_en(tbl_wr),
        .wr_tbl(cmd_r.tbl),
        .wr_idx(cmd_r.idx),
        .wr_data(wword_r),
        .rd_tbl(cmd_r.tbl),
        .rd_idx(cmd_r.idx),
        .rd_data(tbl_rd),
        .mtr_idx(sel_idx),
        .mtr_rate(sel_rate),
        .cbs(cbs_w),
        .ebs(ebs_w)
    );

    irmt_select u_select (
        .mode(cfg_r.mode),
        .key(key_w),
        .idx(sel_idx),
        .idx_ok(sel_ok)
    );

    // meter outputs toward the policer; nothing metered when disabled
    // registered so the policer sees a settled index and rate for a whole cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meter_active_r <= 1'b0;
            meter_idx_r <= '0;
            meter_rate_r <= irmt_pkg::RATE_RESET;
            meter_cbs_r <= irmt_pkg::BURST_RESET;
            meter_ebs_r <= irmt_pkg::BURST_RESET;
        end else begin
            meter_active_r <= cfg_r.enable && key_w.valid && sel_ok;
            meter_idx_r <= sel_idx;
            meter_rate_r <= sel_rate;
            meter_cbs_r <= cbs_w;
            meter_ebs_r <= ebs_w;
        end
    end

    // ------------------------------------------------------------------
    // register read port: data valid the cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_r <= '0;
        end else if (reg_rd && word_ok) begin
            reg_rdata_r <= '0;
            unique case (idx_w)
                irmt_pkg::IDX_CONFIG: reg_rdata_r[2:0] <= {cfg_r.mode, cfg_r.enable};
                irmt_pkg::IDX_COMMAND: reg_rdata_r[7:0] <= cmd_r;
                irmt_pkg::IDX_STATUS: reg_rdata_r[irmt_pkg::STS_PEND_BIT] <= pend_r;
                irmt_pkg::IDX_WRITE_WORD: reg_rdata_r[15:0] <= wword_r;
                irmt_pkg::IDX_READ_WORD: reg_rdata_r[15:0] <= rword_r;
                default: reg_rdata_r <= '0;
            endcase
        end else begin
            reg_rdata_r <= '0;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign meter_active = meter_active_r;
    assign meter_idx = meter_idx_r;
    assign meter_rate = meter_rate_r;
    assign meter_cbs = meter_cbs_r;
    assign meter_ebs = meter_ebs_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_CMD_PEND: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cmd_wr && state_r == ST_IDLE) |=> pend_r [*3] ##1 !pend_r)
        else $error("pending not held three cycles after command");
    AST_DIS_NOMETER: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !cfg_r.enable |=> !meter_active)
        else $error("metering while disabled");
    AST_RD_BEFORE_CLR: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ($fell(pend_r) && cmd_r.dir_read) |-> rword_r == $past(tbl_rd, 2))
        else $error("read word not loaded before pending cleared");
    AST_WR_COMMIT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        tbl_wr |-> (pend_r && !cmd_r.dir_read))
        else $error("table written outside a write access");
    AST_START: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cmd_wr && state_r == ST_IDLE) |=> (state_r == ST_BUSY && cmd_r == $past(wcmd_w)))
        else $error("command not started");
    AST_PORT_MODE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cfg_r.mode == irmt_pkg::IRMT_MODE_PORT && pkt_port < 2'h3)
        |-> sel_idx == 5'(pkt_port))
        else $error("port-only mode index wrong");
    AST_PP_MODE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cfg_r.mode == irmt_pkg::IRMT_MODE_PORT_PRI && pkt_pri < 5'h08)
        |-> sel_idx == {pkt_port, pkt_pri[2:0]})
        else $error("port and priority index wrong");
    AST_PRI_MODE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cfg_r.mode == irmt_pkg::IRMT_MODE_PRI |-> sel_idx == pkt_pri)
        else $error("priority-only index wrong");

    // ------------------------------------------------------------------
    // register port and meter gate checks
    // ------------------------------------------------------------------
    // pending mirrors the sequencer, so a poll can never see a false idle
    AST_PEND_STATE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pend_r == (state_r != ST_IDLE))
        else $error("pending flag out of step with the sequencer");
    AST_BUSY_DROP: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cmd_wr && state_r != ST_IDLE) |=> cmd_r == $past(cmd_r))
        else $error("command taken while an access was running");
    AST_CFG_WR: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (reg_wr && word_ok && idx_w == irmt_pkg::IDX_CONFIG)
        |=> (cfg_r.enable == $past(reg_wdata[irmt_pkg::CFG_EN_BIT])
            && cfg_r.mode == $past(reg_wdata[irmt_pkg::CFG_MODE_LO +: 2])))
        else $error("configuration write not taken");
    AST_STS_READ: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (reg_rd && word_ok && idx_w == irmt_pkg::IDX_STATUS)
        |=> reg_rdata == {31'h0, $past(pend_r)})
        else $error("status read does not show pending");
    AST_RD_WORD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (reg_rd && word_ok && idx_w == irmt_pkg::IDX_READ_WORD)
        |=> reg_rdata == {16'h0, $past(rword_r)})
        else $error("read word not returned in the low half");
    AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !(reg_rd && word_ok) |=> reg_rdata == '0)
        else $error("read data left standing without a read");
    AST_RSVD_MODE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cfg_r.mode == irmt_pkg::IRMT_MODE_RSVD |=> !meter_active)
        else $error("metering in the reserved mode");
    AST_PORT3: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (cfg_r.mode == irmt_pkg::IRMT_MODE_PORT_PRI && pkt_port == 2'h3)
        |=> !meter_active)
        else $error("port without a rate group was metered");
endmodule // irmt_top

// ===== verification/ingress_rate_meter_table_access_tb.sv
`timescale 1ns/1ps
module ingress_rate_meter_table_access_tb;
    // ------------------------------------------------------------------
    // clock, reset and design ports
    // ------------------------------------------------------------------
    localparam logic [14:0] A_CFG = {irmt_pkg::IDX_CONFIG, 2'h0};
    localparam logic [14:0] A_CMD = {irmt_pkg::IDX_COMMAND, 2'h0};
    localparam logic [14:0] A_STS = {irmt_pkg::IDX_STATUS, 2'h0};
    localparam logic [14:0] A_WW = {irmt_pkg::IDX_WRITE_WORD, 2'h0};
    localparam logic [14:0] A_RW = {irmt_pkg::IDX_READ_WORD, 2'h0};
    localparam logic [14:0] A_NONE = 15'h613c; // unmapped word just past the read word
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [14:0] reg_addr = 15'h0000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic pkt_valid = 1'b0;
    logic [1:0] pkt_port = 2'h0;
    logic [4:0] pkt_pri = 5'h00;
    logic meter_active;
    logic [4:0] meter_idx;
    logic [15:0] meter_rate, meter_cbs, meter_ebs;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [15:0] rate_m [24]; // expected table contents
    logic [15:0] cbs_m, ebs_m;

    // 50 ns period
    always #25 sys_clk = ~sys_clk;

    irmt_top u_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_valid(pkt_valid),
        .pkt_port(pkt_port), .pkt_pri(pkt_pri), .meter_active(meter_active),
        .meter_idx(meter_idx), .meter_rate(meter_rate), .meter_cbs(meter_cbs),
        .meter_ebs(meter_ebs)
    );

    // ------------------------------------------------------------------
    // reporting and bus tasks
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: word got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [14:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [14:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // bounded poll: a stuck pending flag ends as a mismatch, not a hang
    task automatic wait_idle();
        logic [31:0] s;
        int n;
        n = 0;
        rd(A_STS, s);
        while (s[0] === 1'b1 && n < 10) begin
            rd(A_STS, s);
            n++;
        end
        chk_word(s, 32'h0);
    endtask

    task automatic access(input logic dir, input logic [1:0] tbl, input logic [4:0] idx,
                          input logic [31:0] wd, input logic [31:0] exp);
        logic [31:0] s;
        if (!dir) wr(A_WW, wd);
        wr(A_CMD, {24'h0, dir, tbl, idx});
        rd(A_STS, s);
        chk_word(s, 32'h1);
        wait_idle();
        if (dir) begin
            rd(A_RW, s);
            chk_word(s, exp);
        end
    endtask

    task automatic key(input logic [1:0] p, input logic [4:0] q, input logic act,
                       input logic [4:0] idx);
        @(posedge sys_clk);
        pkt_valid <= 1'b1;
        pkt_port <= p;
        pkt_pri <= q;
        @(posedge sys_clk);
        #1 chk_bit(meter_active, act);
        if (act) begin
            chk_word({27'h0, meter_idx}, {27'h0, idx});
            chk_word({16'h0, meter_rate}, {16'h0, rate_m[idx]});
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        logic [14:0] al [6];
        al = '{A_CFG, A_CMD, A_STS, A_WW, A_RW, A_NONE};
        foreach (al[i]) begin
            rd(al[i], d);
            chk_word(d, 32'h0);
        end
        chk_word({meter_cbs, meter_ebs}, {irmt_pkg::BURST_RESET, irmt_pkg::BURST_RESET});
    endtask

    task automatic t_defaults();
        access(1'b1, 2'h1, 5'h00, 32'h0, 32'h0014);
        access(1'b1, 2'h1, 5'h17, 32'h0, 32'h0014);
        access(1'b1, 2'h2, 5'h00, 32'h0, 32'h0600);
        access(1'b1, 2'h3, 5'h00, 32'h0, 32'h0600);
        access(1'b1, 2'h0, 5'h00, 32'h0, 32'h0);
    endtask

    task automatic t_writes();
        logic [31:0] d;
        access(1'b0, 2'h1, 5'h05, 32'habcd1234, 32'h0);
        rate_m[5] = 16'h1234;
        access(1'b0, 2'h1, 5'h17, 32'hffffbeef, 32'h0);
        rate_m[23] = 16'hbeef;
        access(1'b0, 2'h2, 5'h00, 32'h00000400, 32'h0);
        access(1'b0, 2'h3, 5'h00, 32'h00000800, 32'h0);
        access(1'b0, 2'h1, 5'h18, 32'h00007777, 32'h0);
        rd(A_WW, d);
        chk_word(d, 32'h00007777);
        access(1'b1, 2'h1, 5'h05, 32'h0, 32'h00001234);
        access(1'b1, 2'h1, 5'h17, 32'h0, 32'h0000beef);
        access(1'b1, 2'h1, 5'h18, 32'h0, 32'h0);
        access(1'b1, 2'h1, 5'h04, 32'h0, 32'h0014);
        access(1'b1, 2'h2, 5'h00, 32'h0, 32'h0400);
        access(1'b1, 2'h3, 5'h00, 32'h0, 32'h0800);
        chk_word({meter_cbs, meter_ebs}, 32'h04000800);
    endtask

    // a second command while pending must be dropped, readback keeps the first
    task automatic t_busy();
        logic [31:0] d;
        wr(A_WW, 32'h00005555);
        wr(A_CMD, {24'h0, 1'b0, 2'h1, 5'h06});
        wr(A_CMD, {24'h0, 1'b0, 2'h1, 5'h07});
        rd(A_CMD, d);
        chk_word(d, {24'h0, 1'b0, 2'h1, 5'h06});
        wait_idle();
        rate_m[6] = 16'h5555;
        access(1'b1, 2'h1, 5'h06, 32'h0, 32'h5555);
        access(1'b1, 2'h1, 5'h07, 32'h0, 32'h0014);
    endtask

    task automatic t_meter();
        logic [31:0] d;
        wr(A_CFG, 32'hfffffff0);
        rd(A_CFG, d);
        chk_word(d, 32'h0);
        key(2'h0, 5'h05, 1'b0, 5'h00);
        wr(A_CFG, 32'h00000001);
        key(2'h0, 5'h05, 1'b1, 5'h05);
        key(2'h1, 5'h00, 1'b1, 5'h08);
        key(2'h2, 5'h07, 1'b1, 5'h17);
        key(2'h3, 5'h00, 1'b0, 5'h00);
        wr(A_CFG, 32'h00000003);
        rd(A_CFG, d);
        chk_word(d, 32'h3);
        key(2'h2, 5'h09, 1'b1, 5'h02);
        key(2'h0, 5'h06, 1'b1, 5'h00);
        wr(A_CFG, 32'h00000005);
        key(2'h1, 5'h17, 1'b1, 5'h17);
        key(2'h2, 5'h06, 1'b1, 5'h06);
        wr(A_CFG, 32'h00000007);
        key(2'h0, 5'h01, 1'b0, 5'h00);
        @(posedge sys_clk);
        pkt_valid <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            $display("Error at %0t: run did not finish in time", $time);
            summarize();
        end
    end

    initial begin
        foreach (rate_m[i]) rate_m[i] = irmt_pkg::RATE_RESET;
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset();
        t_defaults();
        t_writes();
        t_busy();
        t_meter();
        repeat (2) @(posedge sys_clk);
        summarize();
    end
endmodule // ingress_rate_meter_table_access_tb
